// [hw/dmarc_device.sv]

// ****************************************
// Buffer between channel and memory port
// ****************************************
module dmarc_fifo #(
  parameter int W = 24,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("dmarc_fifo: DEPTH must be a power of two, at least 2");
    end
  endgenerate

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
  } dmarc_fifo_type;

  dmarc_fifo_type s_q;
  dmarc_fifo_type s_d;
  logic push;
  logic pop;

  assign in_ready = s_q.cnt != DEPTH[PW:0];
  assign out_valid = s_q.cnt != '0;
  assign out_data = s_q.mem[s_q.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wp] = in_data;
      s_d.wp = s_q.wp + 1'b1;
    end
    if (pop) begin
      s_d.rp = s_q.rp + 1'b1;
    end
    if (push && !pop) begin
      s_d.cnt = s_q.cnt + 1'b1;
    end else if (pop && !push) begin
      s_d.cnt = s_q.cnt - 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule // dmarc_fifo

// ****************************************
// Channel end: registers, request capture, transfer
// ****************************************
module dmarc_device #(
  parameter int DW = 8,
  parameter int NREQ = 16,
  parameter int DEPTH = dmarc_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Register port and peripheral requests
  dmarc_if.dev bus,
  // Memory write stream
  output logic mem_valid,
  input wire logic mem_ready,
  output logic [dmarc_pkg::REG_W-1:0] mem_addr,
  output logic [DW-1:0] mem_data,
  // Status
  output logic chan_active
);
  localparam int RW = dmarc_pkg::REG_W;
  localparam int FW = RW + DW;

  generate
    if (NREQ < 1 || NREQ > dmarc_pkg::MAX_REQ) begin : g_bad_nreq
      $error("dmarc_device: NREQ out of range of the cause selection");
    end
  endgenerate

  typedef struct packed {
    logic [7:0] cause;
    logic [1:0] mode;
    logic [RW-1:0] per_addr;
    logic [RW-1:0] mem_addr;
    logic [RW-1:0] mem_reload;
    logic [RW-1:0] count;
    logic [RW-1:0] count_reload;
    logic [dmarc_pkg::SETTLE_W-1:0] settle;
    logic [RW-1:0] rdata;
    logic rvalid;
    logic ack;
    logic mvalid;
    logic [RW-1:0] maddr;
    logic [DW-1:0] mdata;
    logic active;
  } dmarc_dev_type;

  dmarc_dev_type s_q;
  dmarc_dev_type s_d;

  logic [dmarc_pkg::SEL_W-1:0] sel;
  logic enabled;
  logic runnable;
  logic hw_req;
  logic xfer;
  logic flag_d;
  logic cause_wr;
  logic f_in_ready;
  logic f_out_valid;
  logic f_out_ready;
  logic [FW-1:0] f_out_data;

  assign sel = s_q.cause[dmarc_pkg::SEL_LSB +: dmarc_pkg::SEL_W];
  assign enabled = s_q.mode != dmarc_pkg::MODE_OFF;
  assign runnable = enabled && s_q.count != '0;
  assign cause_wr = bus.sfr_wr && bus.sfr_addr == dmarc_pkg::OFS_CAUSE;
  // A full buffer holds the request pending rather than dropping it
  assign xfer = s_q.cause[dmarc_pkg::FLAG_BIT] && runnable && f_in_ready;

  always_comb begin
    hw_req = 1'b0;
    for (int i = 0; i < NREQ; i++) begin
      if (sel == i[dmarc_pkg::SEL_W-1:0]) begin
        hw_req = bus.per_req[i];
      end
    end
  end

  dmarc_fifo #(
    .W(FW),
    .DEPTH(DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .srst(srst),
    .in_valid(xfer),
    .in_ready(f_in_ready),
    .in_data({s_q.mem_addr, bus.per_data}),
    .out_valid(f_out_valid),
    .out_ready(f_out_ready),
    .out_data(f_out_data)
  );

  assign f_out_ready = !s_q.mvalid || mem_ready;

  always_comb begin
    s_d = s_q;
    // Served or unservable requests drop the flag; a new one in the same cycle wins
    flag_d = s_q.cause[dmarc_pkg::FLAG_BIT];
    if (xfer || !runnable) begin
      flag_d = 1'b0;
    end
    // Writing zero to the flag has no effect; only hardware clears it
    if (hw_req || (cause_wr && bus.sfr_wdata[dmarc_pkg::FLAG_BIT])) begin
      flag_d = 1'b1;
    end
    s_d.ack = xfer;
    if (xfer) begin
      s_d.count = s_q.count - 1'b1;
      s_d.mem_addr = s_q.mem_addr + 1'b1;
      if (s_q.count == 1 && s_q.mode == dmarc_pkg::MODE_REPEAT) begin
        s_d.count = s_q.count_reload;
        s_d.mem_addr = s_q.mem_reload;
      end
    end
    if (s_q.settle != '0) begin
      s_d.settle = s_q.settle - 1'b1;
    end
    if (bus.sfr_wr) begin
      case (bus.sfr_addr)
        dmarc_pkg::OFS_CAUSE: begin
          s_d.cause[6:0] = bus.sfr_wdata[6:0];
          s_d.cause[dmarc_pkg::SWTRIG_BIT] = 1'b0;
          s_d.settle = dmarc_pkg::SETTLE_CYCLES[dmarc_pkg::SETTLE_W-1:0];
        end
        dmarc_pkg::OFS_MODE: begin
          // Enabling inside the settle window is refused; disabling always takes
          if (bus.sfr_wdata[1:0] == dmarc_pkg::MODE_OFF || s_q.settle == '0) begin
            s_d.mode = bus.sfr_wdata[1:0];
          end
        end
        dmarc_pkg::OFS_PER_ADDR: s_d.per_addr = bus.sfr_wdata;
        dmarc_pkg::OFS_MEM_ADDR: s_d.mem_addr = bus.sfr_wdata;
        dmarc_pkg::OFS_MEM_RELOAD: s_d.mem_reload = bus.sfr_wdata;
        dmarc_pkg::OFS_COUNT: s_d.count = bus.sfr_wdata;
        dmarc_pkg::OFS_COUNT_RELOAD: s_d.count_reload = bus.sfr_wdata;
        default: begin
        end
      endcase
    end
    s_d.cause[dmarc_pkg::FLAG_BIT] = flag_d;
    s_d.rvalid = bus.sfr_rd;
    if (bus.sfr_rd) begin
      case (bus.sfr_addr)
        dmarc_pkg::OFS_CAUSE: s_d.rdata = {8'h00, s_q.cause};
        dmarc_pkg::OFS_MODE: s_d.rdata = {14'h0000, s_q.mode};
        dmarc_pkg::OFS_PER_ADDR: s_d.rdata = s_q.per_addr;
        dmarc_pkg::OFS_MEM_ADDR: s_d.rdata = s_q.mem_addr;
        dmarc_pkg::OFS_MEM_RELOAD: s_d.rdata = s_q.mem_reload;
        dmarc_pkg::OFS_COUNT: s_d.rdata = s_q.count;
        dmarc_pkg::OFS_COUNT_RELOAD: s_d.rdata = s_q.count_reload;
        default: s_d.rdata = '0;
      endcase
    end
    if (f_out_valid && f_out_ready) begin
      s_d.mvalid = 1'b1;
      s_d.maddr = f_out_data[FW-1:DW];
      s_d.mdata = f_out_data[DW-1:0];
    end else if (mem_ready) begin
      s_d.mvalid = 1'b0;
    end
    s_d.active = runnable;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign bus.sfr_rdata = s_q.rdata;
  assign bus.sfr_rvalid = s_q.rvalid;
  assign bus.per_ack = s_q.ack;
  assign bus.per_addr = s_q.per_addr;
  assign mem_valid = s_q.mvalid;
  assign mem_addr = s_q.maddr;
  assign mem_data = s_q.mdata;
  assign chan_active = s_q.active;
endmodule // dmarc_device

// [hw/dmarc_host.sv]
// ****************************************
// Software and peripheral end
// ****************************************
module dmarc_host #(
  parameter int DW = 8,
  parameter int NREQ = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Register port and peripheral requests
  dmarc_if.host bus,
  // Job set-up
  input wire logic go,
  input wire logic rewrite_cause,
  input wire logic repeat_mode,
  input wire logic [dmarc_pkg::SEL_W-1:0] cause_sel,
  input wire logic [dmarc_pkg::REG_W-1:0] per_addr,
  input wire logic [dmarc_pkg::REG_W-1:0] mem_addr,
  input wire logic [dmarc_pkg::REG_W-1:0] count,
  input wire logic sw_kick,
  input wire logic stop,
  // Peripheral source
  input wire logic [NREQ-1:0] per_req_in,
  input wire logic [DW-1:0] per_data_in,
  // Status
  output logic busy,
  output logic done
);
  localparam int RW = dmarc_pkg::REG_W;
  localparam int SW = dmarc_pkg::SETTLE_W;

  generate
    if (dmarc_pkg::SETTLE_CYCLES + 1 >= 2 ** SW) begin : g_bad_settle
      $error("dmarc_host: settle counter too narrow");
    end
  endgenerate

  typedef enum logic [9:0] {
    ST_IDLE = 10'b0000000001,
    ST_DIS = 10'b0000000010,
    ST_CAUSE = 10'b0000000100,
    ST_SETR = 10'b0000001000,
    ST_WAIT = 10'b0000010000,
    ST_ENA = 10'b0000100000,
    ST_RUN = 10'b0001000000,
    ST_POFF = 10'b0010000000,
    ST_OFF = 10'b0100000000,
    ST_DONE = 10'b1000000000
  } dmarc_hst_state_type;

  typedef struct packed {
    dmarc_hst_state_type st;
    logic [2:0] idx;
    logic [SW-1:0] wait_cnt;
    logic [7:0] cause;
    logic per_en;
    logic wr;
    logic rd;
    logic [dmarc_pkg::OFS_W-1:0] addr;
    logic [RW-1:0] wdata;
    logic [NREQ-1:0] req;
    logic [DW-1:0] pdata;
    logic busy;
    logic done;
  } dmarc_hst_type;

  dmarc_hst_type s_q;
  dmarc_hst_type s_d;

  // Address and count set-up order
  function automatic logic [dmarc_pkg::OFS_W-1:0] setup_ofs(input logic [2:0] i);
    case (i)
      3'h0: setup_ofs = dmarc_pkg::OFS_PER_ADDR;
      3'h1: setup_ofs = dmarc_pkg::OFS_MEM_RELOAD;
      3'h2: setup_ofs = dmarc_pkg::OFS_MEM_ADDR;
      3'h3: setup_ofs = dmarc_pkg::OFS_COUNT_RELOAD;
      default: setup_ofs = dmarc_pkg::OFS_COUNT;
    endcase
  endfunction

  task automatic reg_write(input logic [dmarc_pkg::OFS_W-1:0] a, input logic [RW-1:0] v);
    s_d.wr = 1'b1;
    s_d.addr = a;
    s_d.wdata = v;
  endtask

  always_comb begin
    s_d = s_q;
    s_d.wr = 1'b0;
    s_d.rd = 1'b0;
    s_d.done = 1'b0;
    // Peripheral raises requests only while it is switched on
    s_d.req = per_req_in & {NREQ{s_q.per_en}};
    s_d.pdata = per_data_in;
    if (s_q.wait_cnt != '0) begin
      s_d.wait_cnt = s_q.wait_cnt - 1'b1;
    end
    case (s_q.st)
      ST_IDLE: begin
        if (go) begin
          s_d.busy = 1'b1;
          s_d.per_en = 1'b0;
          s_d.st = ST_DIS;
        end
      end
      ST_DIS: begin
        reg_write(dmarc_pkg::OFS_MODE, {14'h0000, dmarc_pkg::MODE_OFF});
        s_d.idx = '0;
        s_d.st = rewrite_cause ? ST_CAUSE : ST_SETR;
      end
      ST_CAUSE: begin
        s_d.cause = 8'h00;
        s_d.cause[dmarc_pkg::SEL_LSB +: dmarc_pkg::SEL_W] = cause_sel;
        s_d.cause[dmarc_pkg::FLAG_BIT] = 1'b1;
        reg_write(dmarc_pkg::OFS_CAUSE, {8'h00, s_d.cause});
        // One extra cycle covers the device capturing the write one edge later
        s_d.wait_cnt = SW'(dmarc_pkg::SETTLE_CYCLES + 1);
        s_d.st = ST_SETR;
      end
      ST_SETR: begin
        case (setup_ofs(s_q.idx))
          dmarc_pkg::OFS_PER_ADDR: reg_write(dmarc_pkg::OFS_PER_ADDR, per_addr);
          dmarc_pkg::OFS_MEM_RELOAD: reg_write(dmarc_pkg::OFS_MEM_RELOAD, mem_addr);
          dmarc_pkg::OFS_MEM_ADDR: reg_write(dmarc_pkg::OFS_MEM_ADDR, mem_addr);
          dmarc_pkg::OFS_COUNT_RELOAD: reg_write(dmarc_pkg::OFS_COUNT_RELOAD, count);
          default: reg_write(dmarc_pkg::OFS_COUNT, count);
        endcase
        s_d.idx = s_q.idx + 1'b1;
        if (s_q.idx == 3'h4) begin
          s_d.st = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (s_q.wait_cnt == '0) begin
          s_d.st = ST_ENA;
        end
      end
      ST_ENA: begin
        reg_write(dmarc_pkg::OFS_MODE,
                  {14'h0000, repeat_mode ? dmarc_pkg::MODE_REPEAT : dmarc_pkg::MODE_SINGLE});
        s_d.st = ST_RUN;
      end
      ST_RUN: begin
        s_d.per_en = 1'b1;
        if (stop) begin
          s_d.st = ST_POFF;
        end else if (sw_kick) begin
          // Trigger and flag in one write; the flag is never written as zero
          reg_write(dmarc_pkg::OFS_CAUSE, {8'h00, s_q.cause | dmarc_pkg::SWSTART_MASK});
        end else if (!s_q.rd) begin
          s_d.rd = 1'b1;
          s_d.addr = dmarc_pkg::OFS_COUNT;
        end
        if (bus.sfr_rvalid && bus.sfr_rdata == '0 && !repeat_mode) begin
          s_d.st = ST_POFF;
        end
      end
      ST_POFF: begin
        s_d.per_en = 1'b0;
        s_d.st = ST_OFF;
      end
      ST_OFF: begin
        reg_write(dmarc_pkg::OFS_MODE, {14'h0000, dmarc_pkg::MODE_OFF});
        s_d.st = ST_DONE;
      end
      ST_DONE: begin
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
        s_d.st = ST_IDLE;
      end
      default: s_d.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      s_q <= '0;
      s_q.st <= ST_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign bus.sfr_wr = s_q.wr;
  assign bus.sfr_rd = s_q.rd;
  assign bus.sfr_addr = s_q.addr;
  assign bus.sfr_wdata = s_q.wdata;
  assign bus.per_req = s_q.req;
  assign bus.per_data = s_q.pdata;
  assign busy = s_q.busy;
  assign done = s_q.done;
endmodule // dmarc_host

// [shared/dmarc_if.sv]
interface dmarc_if #(
  parameter int DW = 8,
  parameter int NREQ = 16
) (
  input wire logic mclk,
  input wire logic srst
);
  logic sfr_wr;
  logic sfr_rd;
  logic [dmarc_pkg::OFS_W-1:0] sfr_addr;
  logic [dmarc_pkg::REG_W-1:0] sfr_wdata;
  logic [dmarc_pkg::REG_W-1:0] sfr_rdata;
  logic sfr_rvalid;
  logic [NREQ-1:0] per_req;
  logic [DW-1:0] per_data;
  logic per_ack;
  logic [dmarc_pkg::REG_W-1:0] per_addr;

  modport dev (
    input sfr_wr, sfr_rd, sfr_addr, sfr_wdata, per_req, per_data,
    output sfr_rdata, sfr_rvalid, per_ack, per_addr
  );
  modport host (
    output sfr_wr, sfr_rd, sfr_addr, sfr_wdata, per_req, per_data,
    input sfr_rdata, sfr_rvalid, per_ack, per_addr
  );
endinterface

// [shared/dmarc_pkg.sv]
package dmarc_pkg;
  // ****************************************
  // Register port
  // ****************************************
  localparam int REG_W = 16;
  localparam int OFS_W = 3;
  localparam logic [2:0] OFS_CAUSE = 3'h0;
  localparam logic [2:0] OFS_MODE = 3'h1;
  localparam logic [2:0] OFS_PER_ADDR = 3'h2;
  localparam logic [2:0] OFS_MEM_ADDR = 3'h3;
  localparam logic [2:0] OFS_MEM_RELOAD = 3'h4;
  localparam logic [2:0] OFS_COUNT = 3'h5;
  localparam logic [2:0] OFS_COUNT_RELOAD = 3'h6;
  // ****************************************
  // Request cause register fields
  // ****************************************
  localparam int FLAG_BIT = 7;
  localparam int SWTRIG_BIT = 5;
  localparam int SEL_LSB = 0;
  localparam int SEL_W = 5;
  localparam logic [7:0] SWSTART_MASK = 8'ha0;
  localparam logic [7:0] CAUSE_RST = 8'h00;
  // ****************************************
  // Transfer mode field
  // ****************************************
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_SINGLE = 2'h1;
  localparam logic [1:0] MODE_REPEAT = 2'h3;
  // ****************************************
  // Timing and sizes
  // ****************************************
  localparam int SETTLE_CYCLES = 26;
  localparam int SETTLE_W = 6;
  localparam int FIFO_DEPTH = 4;
  localparam int MAX_REQ = 32;
endpackage

// [test/dmarc_checker.sv]
module dmarc_checker (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Interface signals
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [dmarc_pkg::OFS_W-1:0] sfr_addr,
  input wire logic [dmarc_pkg::REG_W-1:0] sfr_wdata,
  input wire logic sfr_rvalid,
  input wire logic per_ack,
  input wire logic [dmarc_pkg::REG_W-1:0] per_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // Shadow of channel state
  // ********
  logic [4:0] settle_q;
  logic [4:0] sel_q;
  logic en_q;
  logic cause_wr;
  logic mode_wr;
  assign cause_wr = sfr_wr && sfr_addr == dmarc_pkg::OFS_CAUSE;
  assign mode_wr = sfr_wr && sfr_addr == dmarc_pkg::OFS_MODE;
  // Loads one short, so a write on the 26th edge after the cause write is the first legal one
  always_ff @(posedge mclk) begin
    if (srst) begin
      settle_q <= 5'h00;
      sel_q <= 5'h00;
      en_q <= 1'h0;
    end else begin
      if (cause_wr) begin
        settle_q <= 5'(dmarc_pkg::SETTLE_CYCLES - 1);
        sel_q <= sfr_wdata[4:0];
      end else if (settle_q != 5'h00) begin
        settle_q <= settle_q - 5'h01;
      end
      if (mode_wr && (sfr_wdata[1:0] == 2'h0 || settle_q == 5'h00)) begin
        en_q <= sfr_wdata[1:0] != 2'h0;
      end
    end
  end
  // ********
  // Properties
  // ********
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);
  property p_rd_answer;
    sfr_rd |=> sfr_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  property p_rd_only;
    sfr_rvalid |-> $past(sfr_rd);
  endproperty
  a_rd_only: assert property (p_rd_only) else $error("answer without read");
  property p_no_both;
    !(sfr_wr && sfr_rd);
  endproperty
  a_no_both: assert property (p_no_both) else $error("read and write together");
  property p_settle;
    mode_wr && sfr_wdata[1:0] != 2'h0 |-> settle_q == 5'h00;
  endproperty
  a_settle: assert property (p_settle) else $error("enable before settle time");
  property p_trig_flag;
    cause_wr && sfr_wdata[5] |-> sfr_wdata[7];
  endproperty
  a_trig_flag: assert property (p_trig_flag) else $error("trigger without flag");
  property p_flag_kept;
    cause_wr |-> sfr_wdata[dmarc_pkg::FLAG_BIT];
  endproperty
  a_flag_kept: assert property (p_flag_kept) else $error("flag written as zero");
  property p_cause_flag;
    cause_wr && sfr_wdata[4:0] != sel_q |-> sfr_wdata[7];
  endproperty
  a_cause_flag: assert property (p_cause_flag) else $error("cause change without flag");
  property p_sel_off;
    cause_wr && sfr_wdata[4:0] != sel_q |-> !en_q;
  endproperty
  a_sel_off: assert property (p_sel_off) else $error("cause changed while enabled");
  property p_ack_en;
    per_ack |-> $past(en_q);
  endproperty
  a_ack_en: assert property (p_ack_en) else $error("transfer while disabled");
  property p_per_addr;
    sfr_wr && sfr_addr == dmarc_pkg::OFS_PER_ADDR |=> per_addr == $past(sfr_wdata);
  endproperty
  a_per_addr: assert property (p_per_addr) else $error("address not shown");
  c_trig: cover property (cause_wr && sfr_wdata[5]);
  c_ack: cover property (per_ack);
  c_repeat: cover property (mode_wr && sfr_wdata[1:0] == dmarc_pkg::MODE_REPEAT);
endmodule // dmarc_checker

// [test/tb_top.sv]
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, srst, go, rewrite_cause, repeat_mode, sw_kick, stop, mem_ready;
  logic busy, done, mem_valid, chan_active, acked;
  logic [dmarc_pkg::SEL_W-1:0] cause_sel;
  logic [15:0] per_addr_in, mem_addr_in, count, per_req_in, mem_addr;
  logic [7:0] per_data_in, mem_data;
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  int stall;
  int jobs_done = 0;
  logic [23:0] got[$];
  dmarc_if bus_if (.mclk(mclk), .srst(srst));
  dmarc_device dmarc_device_inst (.mclk(mclk), .srst(srst),
    .bus(bus_if), .mem_valid(mem_valid), .mem_ready(mem_ready), .mem_addr(mem_addr),
    .mem_data(mem_data), .chan_active(chan_active));
  dmarc_host dmarc_host_inst (.mclk(mclk), .srst(srst), .bus(bus_if),
    .go(go), .rewrite_cause(rewrite_cause), .repeat_mode(repeat_mode), .cause_sel(cause_sel),
    .per_addr(per_addr_in), .mem_addr(mem_addr_in), .count(count), .sw_kick(sw_kick),
    .stop(stop), .per_req_in(per_req_in), .per_data_in(per_data_in), .busy(busy), .done(done));
  dmarc_checker dmarc_checker_inst (.mclk(mclk), .srst(srst), .sfr_wr(bus_if.sfr_wr),
    .sfr_rd(bus_if.sfr_rd), .sfr_addr(bus_if.sfr_addr), .sfr_wdata(bus_if.sfr_wdata),
    .sfr_rvalid(bus_if.sfr_rvalid), .per_ack(bus_if.per_ack), .per_addr(bus_if.per_addr));
  // ********
  // Clock, timeout, memory monitor
  // ********
  initial begin
    mclk = 1'h0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      complete_run();
    end
  end
  always @(posedge mclk) begin
    if (!srst && mem_valid && mem_ready) begin
      got.push_back({mem_addr, mem_data});
    end
    // The done pulse may pass while a task is still waiting on something else
    if (!srst && done) begin
      jobs_done++;
    end
  end
  // ********
  // Tasks
  // ********
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("compares %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic wait_ack();
    acked = 1'h0;
    for (int i = 0; i < 12 && acked !== 1'h1; i++) begin
      @(negedge mclk);
      acked = bus_if.per_ack;
    end
  endtask
  // Data stays on the line after the pulse, since it is taken only when the flag is served
  task automatic req(input int sel, input logic [7:0] d);
    @(negedge mclk);
    per_req_in[sel] = 1'h1;
    per_data_in = d;
    @(negedge mclk);
    per_req_in = 16'h0000;
    wait_ack();
  endtask
  task automatic start_job(input logic rw, input logic rp,
      input logic [dmarc_pkg::SEL_W-1:0] sel, input logic [15:0] pa, ma, cnt);
    @(negedge mclk);
    rewrite_cause = rw;
    repeat_mode = rp;
    cause_sel = sel;
    per_addr_in = pa;
    mem_addr_in = ma;
    count = cnt;
    go = 1'h1;
    @(negedge mclk);
    go = 1'h0;
    for (int i = 0; i < 80 && chan_active !== 1'h1; i++) begin
      @(negedge mclk);
    end
    repeat (3) @(negedge mclk);
    check(chan_active, 1'h1);
    check(busy, 1'h1);
  endtask
  task automatic end_job(input int n);
    for (int i = 0; i < 200 && jobs_done < n; i++) begin
      @(negedge mclk);
    end
    check(24'(jobs_done), 24'(n));
    check(busy, 1'h0);
    check(chan_active, 1'h0);
    repeat (8) @(negedge mclk);
  endtask
  task automatic expect_mem(input logic [15:0] ma, input logic [7:0] d);
    check(got.size() > 0 ? got.pop_front() : 24'hxxxxxx, {ma, d});
  endtask
  // ********
  // Main sequence
  // ********
  initial begin
    srst = 1'h1;
    go = 1'h0;
    rewrite_cause = 1'h0;
    repeat_mode = 1'h0;
    sw_kick = 1'h0;
    stop = 1'h0;
    mem_ready = 1'h1;
    cause_sel = 5'h00;
    per_addr_in = 16'h0000;
    mem_addr_in = 16'h0000;
    count = 16'h0000;
    per_req_in = 16'h0000;
    per_data_in = 8'h00;
    repeat (12) @(posedge mclk);
    @(negedge mclk);
    srst = 1'h0;
    // Single transfers, memory side stalled until the buffer refuses
    mem_ready = 1'h0;
    start_job(1'h1, 1'h0, 5'h03, 16'h1200, 16'h0040, 16'h0006);
    check(bus_if.per_addr, 16'h1200);
    stall = 6;
    for (int i = 0; i < 6; i++) begin
      req(3, 8'ha0 + 8'(i));
      if (acked !== 1'h1 && stall == 6) begin
        stall = i;
        mem_ready = 1'h1;
        wait_ack();
        check(acked, 1'h1);
      end else begin
        check(acked, 1'h1);
      end
    end
    // Output register plus a full buffer take the first requests
    check(24'(stall), 24'(dmarc_pkg::FIFO_DEPTH + 1));
    req(3, 8'hee);
    check(acked, 1'h0);
    end_job(1);
    for (int i = 0; i < 6; i++) begin
      expect_mem(16'h0040 + 16'(i), 8'ha0 + 8'(i));
    end
    check(24'(got.size()), 24'h000000);
    $display("test single ended");
    // Software trigger on the kept cause
    start_job(1'h0, 1'h0, 5'h03, 16'h1300, 16'h0080, 16'h0001);
    per_data_in = 8'h5c;
    @(negedge mclk);
    sw_kick = 1'h1;
    @(negedge mclk);
    sw_kick = 1'h0;
    wait_ack();
    check(acked, 1'h1);
    end_job(2);
    expect_mem(16'h0080, 8'h5c);
    $display("test trigger ended");
    // Repeat mode reloads address and count
    start_job(1'h1, 1'h1, 5'h09, 16'h1400, 16'h00f0, 16'h0002);
    for (int i = 0; i < 3; i++) begin
      req(9, 8'h31 + 8'(i));
      check(acked, 1'h1);
    end
    @(negedge mclk);
    stop = 1'h1;
    @(negedge mclk);
    stop = 1'h0;
    end_job(3);
    expect_mem(16'h00f0, 8'h31);
    expect_mem(16'h00f1, 8'h32);
    expect_mem(16'h00f0, 8'h33);
    $display("test repeat ended");
    complete_run();
  end
endmodule // tb_top
